// >>> host_bus_model.sv
module host_bus_model (
  input wire logic i_clk,
  input wire logic i_ack_n,
  input wire logic [15:0] i_rdata,
  output logic o_sel_n,
  output logic o_rw_n,
  output logic [5:0] o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  int fails = 0;
  initial begin
    o_sel_n = 1'b1;
    o_rw_n = 1'b1;
    o_addr = 6'h00;
    o_wdata = 16'h0000;
  end
  // ====
  // one word access, held until ack is sampled
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge i_clk);
    #1;
    o_sel_n = 1'b0;
    o_rw_n = rd;
    o_addr = a[6:1];
    o_wdata = rd ? ~o_wdata : d & (a == 7'h00 ? 16'hf9ff : 16'hffff);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack_n !== 1'b0 && n < 8);
    if (i_ack_n !== 1'b0) fails++;
    q = i_rdata;
    #1;
    o_sel_n = 1'b1;
    o_wdata = ~o_wdata;
  endtask
endmodule

// >>> sweep_generator_control_regs.sv
// Function
// (R1) Writing 1 to self-test request starts a test; bit self-clears when done.
// (R2) Output forced off while self-test runs, programmed enable restored after.
// (R3) Status bits 12..15 hold per-range test outcome, 1 = fail, read-only.
// (R4) Reading the status/control register clears all four outcome bits.
// (R5) Pause bit freezes any sweep in progress; clearing resumes.
// (R6) Mode: fixed A, single ramp, single cycle, continuous cycle, 1xx reserved.
// (R7) Strobe polarity: 0 external trigger active low, 1 active high.
// (R8) Strobe enable 0 ignores strobe; 1 lets strobe govern sweeping with run set.
// (R9) Single modes with strobe: active edge triggers a sequence running to end.
// (R10) Fixed and continuous with strobe: advance only while strobe active.
// (R11) Renewed strobe after such a hold jumps to A and restarts.
// (R12) Strobe has influence only while run bit is set.
// (R13) Run cleared holds frequency; set again jumps to A and restarts.
// (R14) Output enable bit gates the generated signal onto the output.
// (R15) 5-bit duty code, default 0x0f, maps 85 to 15 percent.
// (R16) Two 8-bit amplitude codes for A and B, default zero.
// (R17) Two 8-bit offset codes for A and B, default mid code.
// (R18) Frequency A bit 15 selects programmed or current frequency read-back.
// (R19) Dwell at A for count times unit of ms, 10 ms, 100 ms, s.
// (R20) Slew A sets ramp rate from A toward B.
// (R21) Host keeps read-back info select and correction-off bits at 0.
// (R22) Internal strobe is OR of bus strobe and external trigger.
// (R23) Slew code rate rises 5 percent per step; 0x7f changes immediately.
// (R24) Frequency step per code follows selected range, 1 Hz up to 1000 Hz.
// (R25) Range field 0..3 lowest to highest; shape square, triangle, sine.
// (R26) Dwell and slew timing derived by counting module clock cycles.
`include "sweep_params.svh"

module sweep_generator_control_regs #(
  parameter int CYCLES_PER_MS = `SWP_CYCLES_PER_MS,
  parameter int SELFTEST_CYCLES = `SWP_SELFTEST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_io_sel_n,
  input wire logic i_rw_n,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  output logic o_ack_n,
  input wire logic i_bus_strobe_n,
  input wire logic i_external_trigger_n,
  input wire logic [9:0] i_freq_b,
  input wire logic [15:0] i_dwell_slew_b,
  input wire logic [3:0] i_range_fault,
  output logic o_output_drive_enable,
  output logic [1:0] o_wave_shape_select,
  output logic [4:0] o_duty_code,
  output logic [1:0] o_range_select,
  output logic [7:0] o_amplitude_code,
  output logic [7:0] o_offset_code,
  output logic [9:0] o_freq_code,
  output logic o_freq_correction_disable,
  output logic o_readback_info_select
);

  // =====================================================================
  // slew rate in codes per s, 20 * 1.05^v via piecewise 2^x
  function automatic logic [15:0] slew_rate(input logic [6:0] v);
    logic [16:0] prod;
    logic [3:0] k;
    logic [9:0] f;
    logic [15:0] mant;
    logic [25:0] scaled;
    prod = 17'(v) * 17'd577;
    k = prod[16:13];
    f = prod[12:3];
    mant = `SWP_SLEW_BASE_RATE * (16'd1024 + 16'(f));
    scaled = 26'(mant) << k;
    slew_rate = scaled[25:10];
  endfunction

  // =====================================================================
  // registers
  sweep_pkg::ctrl_s ctrl_reg;
  logic [4:0] duty_reg;
  logic [1:0] range_reg;
  logic [1:0] shape_reg;
  logic [7:0] ampl_a_reg;
  logic [7:0] ampl_b_reg;
  logic [7:0] offs_a_reg;
  logic [7:0] offs_b_reg;
  logic [9:0] freq_a_reg;
  logic freq_rbsel_reg;
  sweep_pkg::dwell_slew_s dsl_a_reg;
  sweep_pkg::dwell_slew_s dsl_b;

  // bus
  logic busy_reg;
  logic ack_n_reg;
  logic oe_reg;
  logic [15:0] rdata_reg;
  logic take;
  logic wr;
  logic rd;
  logic [6:0] byte_addr;
  logic sel_ctrl;
  logic sel_wave;
  logic sel_ampl;
  logic sel_offs;
  logic sel_frqa;
  logic sel_dsla;
  logic [15:0] rmux;

  // sweep
  sweep_pkg::sweep_state_e state_reg;
  sweep_pkg::sweep_state_e state_next;
  logic [9:0] freq_reg;
  logic [9:0] freq_next;
  logic [5:0] dwell_cnt_reg;
  logic [5:0] dwell_cnt_next;
  logic [17:0] acc_reg;
  logic [17:0] acc_next;
  logic at_b_reg;
  logic at_b_next;
  logic run_d_reg;
  logic strobe_d_reg;
  logic ext_active;
  logic strobe_active;
  logic run_rise;
  logic strobe_rise;
  logic single_mode;
  logic reserved_mode;
  logic restart;
  logic advance;
  logic in_dwell;
  logic [1:0] dwell_unit;
  logic [5:0] dwell_target;
  logic [6:0] slew_code;
  logic [15:0] rate;
  logic [9:0] target;
  logic ramping;
  logic step;
  logic ms_tick;
  logic unit_tick;
  logic dwell_done;

  // selftest
  logic st_start;
  logic st_busy;
  logic st_done;
  logic [3:0] st_result;

  // =====================================================================
  // bus decode
  assign byte_addr = {i_addr, 1'b0};
  assign take = !i_io_sel_n && !busy_reg;
  assign wr = take && !i_rw_n;
  assign rd = take && i_rw_n;
  assign sel_ctrl = (byte_addr == `SWP_OFF_CTRL);
  assign sel_wave = (byte_addr == `SWP_OFF_WAVE);
  assign sel_ampl = (byte_addr == `SWP_OFF_AMPL);
  assign sel_offs = (byte_addr == `SWP_OFF_OFFS);
  assign sel_frqa = (byte_addr == `SWP_OFF_FRQA);
  assign sel_dsla = (byte_addr == `SWP_OFF_DSLA);
  assign dsl_b = i_dwell_slew_b;

  assign rmux = sel_ctrl ? ctrl_reg :
                sel_wave ? {3'h0, duty_reg, 2'h0, range_reg, 2'h0, shape_reg} :
                sel_ampl ? {ampl_b_reg, ampl_a_reg} :
                sel_offs ? {offs_b_reg, offs_a_reg} :
                sel_frqa ? {freq_rbsel_reg, 5'h00, (freq_rbsel_reg ? freq_reg : freq_a_reg)} :  // [R18]
                sel_dsla ? dsl_a_reg :
                16'h0000;

  assign st_start = wr && sel_ctrl && i_data[8] && !st_busy;  // [R1]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      ack_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      busy_reg <= take || (busy_reg && !i_io_sel_n);
      ack_n_reg <= !take;
      oe_reg <= rd;
      rdata_reg <= rd ? rmux : 16'h0000;
    end
  end

  // =====================================================================
  // status/control register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= `SWP_RST_CTRL;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl_reg.readback_info_select <= i_data[10];  // [R21]
        ctrl_reg.freq_correction_disable <= i_data[9];
        ctrl_reg.sweep_pause <= i_data[7];
        ctrl_reg.mode <= i_data[6:4];
        ctrl_reg.strobe_polarity <= i_data[3];
        ctrl_reg.strobe_gate_enable <= i_data[2];
        ctrl_reg.run <= i_data[1];
        ctrl_reg.output_drive_enable <= i_data[0];
      end
      // a new request wins over completion of the previous run
      if (st_start) begin
        ctrl_reg.selftest_request <= 1'b1;  // [R1]
      end else if (st_done) begin
        ctrl_reg.selftest_request <= 1'b0;  // [R1]
      end
      // completion sets outcome even in the cycle of a clearing read
      if (st_done) begin
        ctrl_reg.result <= st_result;  // [R3]
      end else if (rd && sel_ctrl) begin
        ctrl_reg.result <= 4'h0;  // [R4]
      end
    end
  end

  // =====================================================================
  // waveform, level and frequency A registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      duty_reg <= `SWP_RST_DUTY;
      range_reg <= `SWP_RST_RANGE;
      shape_reg <= `SWP_RST_SHAPE;
      ampl_a_reg <= `SWP_RST_AMPL;
      ampl_b_reg <= `SWP_RST_AMPL;
      offs_a_reg <= `SWP_RST_OFFS;
      offs_b_reg <= `SWP_RST_OFFS;
      freq_a_reg <= `SWP_RST_FREQ;
      freq_rbsel_reg <= 1'b0;
      dsl_a_reg <= `SWP_RST_DSL;
    end else if (wr) begin
      if (sel_wave) begin
        duty_reg <= i_data[`SWP_WAVE_DUTY_LSB +: 5];  // [R15]
        range_reg <= i_data[`SWP_WAVE_RANGE_LSB +: 2];  // [R25]
        shape_reg <= i_data[1:0];  // [R25]
      end
      if (sel_ampl) begin
        ampl_a_reg <= i_data[7:0];  // [R16]
        ampl_b_reg <= i_data[15:8];  // [R16]
      end
      if (sel_offs) begin
        offs_a_reg <= i_data[7:0];  // [R17]
        offs_b_reg <= i_data[15:8];  // [R17]
      end
      if (sel_frqa) begin
        freq_a_reg <= i_data[9:0];
        freq_rbsel_reg <= i_data[`SWP_FRQA_RBSEL_BIT];  // [R18]
      end
      if (sel_dsla) begin
        dsl_a_reg <= {i_data[15:8], 1'b0, i_data[6:0]};  // [R19] [R20]
      end
    end
  end

  // =====================================================================
  // strobe and run conditioning
  assign ext_active = ctrl_reg.strobe_polarity ? i_external_trigger_n : !i_external_trigger_n;  // [R7]
  assign strobe_active = !i_bus_strobe_n || ext_active;  // [R22]
  assign run_rise = ctrl_reg.run && !run_d_reg;
  assign strobe_rise = strobe_active && !strobe_d_reg;
  assign single_mode = (ctrl_reg.mode == sweep_pkg::MODE_SINGLE_RAMP) ||
                       (ctrl_reg.mode == sweep_pkg::MODE_SINGLE_CYCLE);
  assign reserved_mode = ctrl_reg.mode[2];  // [R6]
  assign restart = run_rise ||
                   (ctrl_reg.run && ctrl_reg.strobe_gate_enable && strobe_rise);  // [R11] [R12] [R13]
  assign advance = ctrl_reg.run && !ctrl_reg.sweep_pause && !reserved_mode &&
                   (!ctrl_reg.strobe_gate_enable || single_mode || strobe_active);  // [R5] [R8] [R10]

  // =====================================================================
  // dwell and slew timing
  assign in_dwell = (state_reg == sweep_pkg::ST_DWELL_A) || (state_reg == sweep_pkg::ST_DWELL_B);
  assign dwell_unit = (state_reg == sweep_pkg::ST_DWELL_B) ? dsl_b.dwell_unit : dsl_a_reg.dwell_unit;
  assign dwell_target = (state_reg == sweep_pkg::ST_DWELL_B) ? dsl_b.dwell : dsl_a_reg.dwell;
  assign slew_code = (state_reg == sweep_pkg::ST_RAMP_BA) ? dsl_b.slew : dsl_a_reg.slew;
  assign rate = slew_rate(slew_code);  // [R23]
  assign target = (state_reg == sweep_pkg::ST_RAMP_BA) ? freq_a_reg : i_freq_b;
  assign ramping = (state_reg == sweep_pkg::ST_RAMP_AB) || (state_reg == sweep_pkg::ST_RAMP_BA);
  assign step = advance && ramping && (acc_reg >= `SWP_RATE_PER_STEP) && (freq_reg != target);  // [R20]
  assign dwell_done = (dwell_cnt_reg >= dwell_target);

  sweep_timebase #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timebase (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_restart(restart || (state_reg != state_next)),
    .i_enable(advance),
    .i_dwell_unit(dwell_unit),
    .o_ms_tick(ms_tick),
    .o_unit_tick(unit_tick)
  );

  // =====================================================================
  // sweep sequencer
  always_comb begin
    state_next = state_reg;
    freq_next = freq_reg;
    dwell_cnt_next = dwell_cnt_reg;
    acc_next = acc_reg;
    at_b_next = at_b_reg;
    if (restart) begin
      freq_next = freq_a_reg;  // [R11] [R13]
      dwell_cnt_next = 6'h00;
      acc_next = 18'h00000;
      at_b_next = 1'b0;
      state_next = (single_mode && ctrl_reg.strobe_gate_enable && !strobe_rise) ?
                   sweep_pkg::ST_ARMED : sweep_pkg::ST_DWELL_A;  // [R9]
    end else if (advance) begin
      unique case (state_reg)
        sweep_pkg::ST_ARMED: begin
          freq_next = freq_a_reg;
        end
        sweep_pkg::ST_DWELL_A, sweep_pkg::ST_DWELL_B: begin
          if (ctrl_reg.mode == sweep_pkg::MODE_FIXED) begin
            freq_next = freq_a_reg;  // [R6]
          end else if (dwell_done) begin
            state_next = (state_reg == sweep_pkg::ST_DWELL_A) ? sweep_pkg::ST_RAMP_AB :
                                                                sweep_pkg::ST_RAMP_BA;  // [R19]
            dwell_cnt_next = 6'h00;
            acc_next = 18'h00000;
          end else if (unit_tick) begin
            dwell_cnt_next = dwell_cnt_reg + 6'h01;  // [R19] [R26]
          end
        end
        sweep_pkg::ST_RAMP_AB, sweep_pkg::ST_RAMP_BA: begin
          if (freq_reg == target) begin
            at_b_next = (state_reg == sweep_pkg::ST_RAMP_AB);
            unique case (ctrl_reg.mode)
              sweep_pkg::MODE_SINGLE_RAMP: state_next = sweep_pkg::ST_DONE;  // [R6]
              sweep_pkg::MODE_SINGLE_CYCLE: state_next = (state_reg == sweep_pkg::ST_RAMP_AB) ?
                                                         sweep_pkg::ST_DWELL_B : sweep_pkg::ST_DONE;
              default: state_next = (state_reg == sweep_pkg::ST_RAMP_AB) ?
                                    sweep_pkg::ST_DWELL_B : sweep_pkg::ST_DWELL_A;
            endcase
          end else if (slew_code == `SWP_SLEW_IMMEDIATE) begin
            freq_next = target;  // [R23]
          end else begin
            acc_next = acc_reg + (ms_tick ? 18'(rate) : 18'h00000) -
                       (step ? `SWP_RATE_PER_STEP : 18'h00000);  // [R26]
            if (step) begin
              freq_next = (freq_reg < target) ? freq_reg + 10'h001 : freq_reg - 10'h001;
            end
          end
        end
        sweep_pkg::ST_DONE: begin
        end
        default: begin
          state_next = sweep_pkg::ST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= sweep_pkg::ST_DONE;
      freq_reg <= `SWP_RST_FREQ;
      dwell_cnt_reg <= 6'h00;
      acc_reg <= 18'h00000;
      at_b_reg <= 1'b0;
      run_d_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      freq_reg <= freq_next;
      dwell_cnt_reg <= dwell_cnt_next;
      acc_reg <= acc_next;
      at_b_reg <= at_b_next;
      run_d_reg <= ctrl_reg.run;
      strobe_d_reg <= strobe_active;
    end
  end

  // =====================================================================
  // self-test engine
  sweep_selftest #(
    .SELFTEST_CYCLES(SELFTEST_CYCLES)
  ) u_selftest (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(st_start),
    .i_range_fault(i_range_fault),
    .o_busy(st_busy),
    .o_done(st_done),
    .o_result(st_result)
  );

  // =====================================================================
  // registered outputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_output_drive_enable <= 1'b0;
      o_wave_shape_select <= `SWP_RST_SHAPE;
      o_duty_code <= `SWP_RST_DUTY;
      o_range_select <= `SWP_RST_RANGE;
      o_amplitude_code <= `SWP_RST_AMPL;
      o_offset_code <= `SWP_RST_OFFS;
      o_freq_code <= `SWP_RST_FREQ;
      o_freq_correction_disable <= 1'b0;
      o_readback_info_select <= 1'b0;
    end else begin
      o_output_drive_enable <= ctrl_reg.output_drive_enable && !st_busy && !st_start;  // [R2] [R14]
      o_wave_shape_select <= shape_reg;  // [R25]
      o_duty_code <= duty_reg;  // [R15]
      o_range_select <= range_reg;  // [R24]
      o_amplitude_code <= at_b_next ? ampl_b_reg : ampl_a_reg;  // [R16]
      o_offset_code <= at_b_next ? offs_b_reg : offs_a_reg;  // [R17]
      o_freq_code <= freq_next;
      o_freq_correction_disable <= ctrl_reg.freq_correction_disable;
      o_readback_info_select <= ctrl_reg.readback_info_select;
    end
  end

  assign o_data = rdata_reg;
  assign o_data_oe = oe_reg;
  assign o_ack_n = ack_n_reg;

endmodule

// >>> sweep_generator_control_regs_monitor.sv
module sweep_regs_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_io_sel_n,
  input wire logic i_rw_n,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [15:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_ack_n,
  input wire logic o_output_drive_enable,
  input wire logic [4:0] o_duty_code,
  input wire logic [1:0] o_range_select,
  input wire logic [9:0] o_freq_code
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ====
  // first low cycle of select is the take
  logic sel_reg;
  wire logic take = sel_reg & ~i_io_sel_n;
  wire logic wr_ctrl = take & ~i_rw_n & (i_addr == 6'h00);
  wire logic wr_wave = take & ~i_rw_n & (i_addr == 6'h01);
  always_ff @(posedge i_clk) begin
    sel_reg <= i_sys_rst | i_io_sel_n;
  end
  // ====
  // checks
  take_ack_a: assert property (take |=> !o_ack_n)
    else $error("access not acknowledged");
  ack_pulse_a: assert property (!o_ack_n |=> o_ack_n)
    else $error("ack longer than one cycle");
  read_oe_a: assert property (take && i_rw_n |=> o_data_oe ##1 !o_data_oe)
    else $error("read data enable wrong");
  write_quiet_a: assert property (take && !i_rw_n |=> !o_data_oe && o_data == 16'h0000)
    else $error("data driven on write");
  test_off_a: assert property (wr_ctrl && i_data[8] |=> !o_output_drive_enable [*6])
    else $error("output on during self-test");
  oen_gate_a: assert property (wr_ctrl && !i_data[0] |=> ##1 !o_output_drive_enable [*2])
    else $error("output on while disabled");
  run_hold_a: assert property (wr_ctrl && !i_data[1] |=> ##2 $stable(o_freq_code) [*2])
    else $error("frequency moved while stopped");
  mode_hold_a: assert property (wr_ctrl && i_data[6] |=> ##2 $stable(o_freq_code) [*2])
    else $error("frequency moved in reserved mode");
  duty_copy_a: assert property (wr_wave |=> ##1 o_duty_code == $past(i_data[12:8], 2))
    else $error("duty code not applied");
  range_copy_a: assert property (wr_wave |=> ##1 o_range_select == $past(i_data[5:4], 2))
    else $error("range not applied");
endmodule
bind sweep_generator_control_regs sweep_regs_monitor u_mon (.*);

// >>> sweep_generator_control_regs_tb.sv
module sweep_generator_control_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_sys_rst = 1, i_io_sel_n, i_rw_n, i_bus_strobe_n = 1, i_external_trigger_n = 1;
  logic [5:0] i_addr;
  logic [15:0] i_data, o_data, q;
  logic [9:0] i_freq_b = 10'h200;
  logic [15:0] i_dwell_slew_b = 16'h017f;
  logic [3:0] i_range_fault = 4'ha;
  logic o_data_oe, o_ack_n, o_output_drive_enable, o_freq_correction_disable, o_readback_info_select;
  logic [1:0] o_wave_shape_select, o_range_select;
  logic [4:0] o_duty_code;
  logic [7:0] o_amplitude_code, o_offset_code;
  logic [9:0] o_freq_code;
  int err_total = 0, comparisons = 0;
  sweep_generator_control_regs #(.CYCLES_PER_MS(20), .SELFTEST_CYCLES(8)) u_dut (.*);
  host_bus_model u_host (.i_clk(i_clk), .i_ack_n(o_ack_n), .i_rdata(o_data), .o_sel_n(i_io_sel_n),
    .o_rw_n(i_rw_n), .o_addr(i_addr), .o_wdata(i_data));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ====
  // helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    err_total += u_host.fails;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    u_host.xfer(1'b1, a, 16'h0000, q);
    check("register", q, exp);
  endtask
  task automatic fq(input logic [9:0] exp, input int n);
    for (int i = 0; i < n && o_freq_code !== exp; i++) @(posedge i_clk);
    #1;
    check("freq", o_freq_code, exp);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    final_report();
  end
  // ====
  // main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_sys_rst = 0;
    rd(7'h00, 16'h0000);
    rd(7'h02, 16'h0f00);
    rd(7'h04, 16'h0000);
    rd(7'h06, 16'h8080);
    rd(7'h08, 16'h0000);
    rd(7'h0c, 16'h0000);
    wr(7'h00, 16'hf001);
    rd(7'h00, 16'h0001);
    wr(7'h02, 16'hffff);
    rd(7'h02, 16'h1f33);
    check("shape", o_wave_shape_select, 2'h3);
    wr(7'h04, 16'h3c11);
    rd(7'h04, 16'h3c11);
    wr(7'h06, 16'h00ff);
    rd(7'h06, 16'h00ff);
    wr(7'h0a, 16'hffff);
    rd(7'h0a, 16'hff7f);
    wr(7'h00, 16'h0101);
    check("oen", o_output_drive_enable, 1'b0);
    rd(7'h00, 16'h0101);
    repeat (12) @(posedge i_clk);
    rd(7'h00, 16'ha001);
    rd(7'h00, 16'h0001);
    check("oen", o_output_drive_enable, 1'b1);
    wr(7'h0a, 16'h007f);
    wr(7'h08, 16'h0123);
    wr(7'h00, 16'h0003);
    fq(10'h123, 20);
    wr(7'h08, 16'h8155);
    fq(10'h155, 20);
    wr(7'h00, 16'h0001);
    wr(7'h08, 16'h8066);
    rd(7'h08, 16'h8155);
    wr(7'h08, 16'h0066);
    rd(7'h08, 16'h0066);
    wr(7'h00, 16'h0003);
    fq(10'h066, 20);
    wr(7'h00, 16'h0007);
    wr(7'h08, 16'h00aa);
    repeat (30) @(posedge i_clk);
    fq(10'h066, 0);
    i_external_trigger_n = 0;
    fq(10'h0aa, 20);
    i_external_trigger_n = 1;
    wr(7'h08, 16'h00bb);
    i_bus_strobe_n = 0;
    fq(10'h0bb, 20);
    i_bus_strobe_n = 1;
    wr(7'h00, 16'h000f);
    wr(7'h08, 16'h00cc);
    fq(10'h0cc, 20);
    wr(7'h00, 16'h0011);
    wr(7'h00, 16'h0013);
    fq(10'h200, 20);
    check("ampl", o_amplitude_code, 8'h3c);
    check("offs", o_offset_code, 8'h00);
    wr(7'h00, 16'h0011);
    wr(7'h00, 16'h0017);
    repeat (20) @(posedge i_clk);
    fq(10'h0cc, 0);
    i_external_trigger_n = 0;
    @(posedge i_clk);
    #1;
    i_external_trigger_n = 1;
    fq(10'h200, 20);
    wr(7'h00, 16'h0021);
    wr(7'h00, 16'h0023);
    repeat (40) @(posedge i_clk);
    fq(10'h0cc, 0);
    check("ampl", o_amplitude_code, 8'h11);
    wr(7'h0a, 16'h017f);
    wr(7'h00, 16'h0031);
    wr(7'h00, 16'h0033);
    fq(10'h200, 60);
    fq(10'h0cc, 60);
    wr(7'h00, 16'h00b3);
    repeat (60) @(posedge i_clk);
    fq(10'h0cc, 0);
    wr(7'h00, 16'h0033);
    fq(10'h200, 60);
    wr(7'h00, 16'h0043);
    wr(7'h00, 16'h0042);
    check("oen", o_output_drive_enable, 1'b0);
    check("fco", o_freq_correction_disable, 1'b0);
    check("rbi", o_readback_info_select, 1'b0);
    repeat (10) @(posedge i_clk);
    final_report();
  end
endmodule

// >>> sweep_params.svh
`ifndef SWEEP_PARAMS_SVH
`define SWEEP_PARAMS_SVH

// =====================================================================
// register byte offsets
`define SWP_OFF_CTRL 7'h00
`define SWP_OFF_WAVE 7'h02
`define SWP_OFF_AMPL 7'h04
`define SWP_OFF_OFFS 7'h06
`define SWP_OFF_FRQA 7'h08
`define SWP_OFF_DSLA 7'h0a

// =====================================================================
// field positions
`define SWP_CTRL_RESULT_LSB 12
`define SWP_WAVE_DUTY_LSB 8
`define SWP_WAVE_RANGE_LSB 4
`define SWP_FRQA_RBSEL_BIT 15
`define SWP_DSL_UNIT_LSB 14
`define SWP_DSL_DWELL_LSB 8

// =====================================================================
// reset values
`define SWP_RST_CTRL 16'h0000
`define SWP_RST_DUTY 5'h0f
`define SWP_RST_RANGE 2'h0
`define SWP_RST_SHAPE 2'h0
`define SWP_RST_AMPL 8'h00
`define SWP_RST_OFFS 8'h80
`define SWP_RST_FREQ 10'h000
`define SWP_RST_DSL 16'h0000

// =====================================================================
// slew encoding
`define SWP_SLEW_IMMEDIATE 7'h7f
`define SWP_SLEW_BASE_RATE 16'd20
`define SWP_RATE_PER_STEP 18'd1000

// =====================================================================
// timing
`define SWP_CLK_PERIOD_NS 10
`define SWP_MS_NS 1000000
`define SWP_SELFTEST_US 100
`define SWP_CYCLES_PER_MS (`SWP_MS_NS / `SWP_CLK_PERIOD_NS)
`define SWP_SELFTEST_CYCLES ((`SWP_SELFTEST_US * 1000) / `SWP_CLK_PERIOD_NS)

`endif

// >>> sweep_pkg.sv
package sweep_pkg;

  typedef enum logic [2:0] {
    MODE_FIXED,
    MODE_SINGLE_RAMP,
    MODE_SINGLE_CYCLE,
    MODE_CONT_CYCLE
  } slew_mode_e;

  typedef enum logic [2:0] {
    ST_ARMED,
    ST_DWELL_A,
    ST_RAMP_AB,
    ST_DWELL_B,
    ST_RAMP_BA,
    ST_DONE
  } sweep_state_e;

  typedef struct packed {
    logic [3:0] result;
    logic spare;
    logic readback_info_select;
    logic freq_correction_disable;
    logic selftest_request;
    logic sweep_pause;
    logic [2:0] mode;
    logic strobe_polarity;
    logic strobe_gate_enable;
    logic run;
    logic output_drive_enable;
  } ctrl_s;

  typedef struct packed {
    logic [1:0] dwell_unit;
    logic [5:0] dwell;
    logic spare;
    logic [6:0] slew;
  } dwell_slew_s;

endpackage

// >>> sweep_selftest.sv
module sweep_selftest #(
  parameter int SELFTEST_CYCLES = 10000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [3:0] i_range_fault,
  output logic o_busy,
  output logic o_done,
  output logic [3:0] o_result
);

  logic [15:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [3:0] result_reg;
  logic last;

  assign last = (cnt_reg == 16'(SELFTEST_CYCLES - 1));
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_result = result_reg;

  // =====================================================================
  // range check run, one outcome per range
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= 4'h0;
    end else begin
      done_reg <= busy_reg && last;
      if (busy_reg && last) begin
        busy_reg <= 1'b0;
        result_reg <= i_range_fault;  // [R3]
      end else if (i_start && !busy_reg) begin
        busy_reg <= 1'b1;  // [R1]
        cnt_reg <= 16'h0000;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule

// >>> sweep_timebase.sv
module sweep_timebase #(
  parameter int CYCLES_PER_MS = 100000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_restart,
  input wire logic i_enable,
  input wire logic [1:0] i_dwell_unit,
  output logic o_ms_tick,
  output logic o_unit_tick
);

  logic [16:0] ms_cnt_reg;
  logic [9:0] unit_cnt_reg;
  logic [9:0] unit_limit;
  logic ms_wrap;
  logic unit_wrap;

  // =====================================================================
  // unit divider: ms, 10 ms, 100 ms, 1 s
  assign unit_limit = (i_dwell_unit == 2'h0) ? 10'd0 :
                      (i_dwell_unit == 2'h1) ? 10'd9 :
                      (i_dwell_unit == 2'h2) ? 10'd99 : 10'd999;
  assign ms_wrap = (ms_cnt_reg == 17'(CYCLES_PER_MS - 1));
  assign unit_wrap = ms_wrap && (unit_cnt_reg >= unit_limit);
  assign o_ms_tick = i_enable && ms_wrap;
  assign o_unit_tick = i_enable && unit_wrap;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_restart) begin
      ms_cnt_reg <= 17'h00000;
      unit_cnt_reg <= 10'h000;
    end else if (i_enable) begin
      ms_cnt_reg <= ms_wrap ? 17'h00000 : ms_cnt_reg + 17'h00001;  // [R26]
      if (ms_wrap) begin
        unit_cnt_reg <= unit_wrap ? 10'h000 : unit_cnt_reg + 10'h001;  // [R19]
      end
    end
  end

endmodule
